// ### rtl/mfe_top.sv
/*
 * mfe_top: translation lookup with fault detection, fault state capture,
 * replacement way upkeep, entry load and the mapped entry window.
 * assumes all inputs come from core logic on mclk_i; one request a cycle.
 */
// Behaviour
// - valid hit without rights gives protection fault
// - protection codes 0a0 load, 0c0 store
// - invalid match gives codes 040/060
// - store to clean permitted page gives 080
// - capture page number and faulting address
// - saved pc is branch address in slot
// - save status, set mode, mask, bank
// - faulting way goes to replacement field
// - these faults vector to base plus 100
// - repeat loop faults are not restartable
// - repeat loop codes 070 or 0d0
// - only last four loop instructions count; the code also counts the instruction just before the loop (rpt_pre)
// - tag window f2, data window f3
// - valid bit also reachable via data window
// - miss updates replacement field by priority, or adds one when all ways valid
// - miss outside loop zone vectors to base plus 400
module mfe_top (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire mfe_pkg::mfe_req_t req_i,
    input wire logic [31:0] vbr_i,
    input wire logic load_translation_entry_instr_i,
    input wire logic [31:0] page_entry_low_i,
    input wire logic page_entry_high_wr_i,
    input wire logic [31:0] page_entry_high_wdata_i,
    input wire logic rc_wr_i,
    input wire logic [1:0] rc_wdata_i,
    input wire logic win_valid_i,
    input wire logic win_wr_i,
    input wire logic win_long_i,
    input wire logic win_priv_i,
    input wire logic [31:0] win_addr_i,
    input wire logic [31:0] win_wdata_i,
    output logic done_o,
    output logic fault_o,
    output mfe_pkg::mfe_fault_t fault_info_o,
    output logic [31:0] paddr_o,
    output logic [31:0] page_entry_high_o,
    output logic [1:0] replacement_way_field_o,
    output logic win_ack_o,
    output logic win_err_o,
    output logic [31:0] win_rdata_o
);
    // ==================================================
    // helpers
    // lowest set bit of a way vector
    function automatic logic [1:0] first_one(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h3;
        for (int i = 3; i >= 0; i--)
        begin
            if (v[i])
                r = 2'(i);
        end
        return r;
    endfunction : first_one

    // window kind from the select byte
    function automatic mfe_pkg::mfe_win_t win_kind(input logic [7:0] s);
        if (s == mfe_pkg::WIN_TAG_SEL)
            return mfe_pkg::WIN_TAGS;
        else if (s == mfe_pkg::WIN_DATA_SEL)
            return mfe_pkg::WIN_DATAS;
        return mfe_pkg::WIN_NONE;
    endfunction : win_kind

    // ==================================================
    // entry store
    logic [mfe_pkg::VPN_W-1:0] tag_vpn [mfe_pkg::WAYS][mfe_pkg::SETS];
    logic [mfe_pkg::ASID_W-1:0] tag_asid [mfe_pkg::WAYS][mfe_pkg::SETS];
    logic tag_v [mfe_pkg::WAYS][mfe_pkg::SETS];
    logic [31:0] data_w [mfe_pkg::WAYS][mfe_pkg::SETS];

    logic [4:0] idx; // set selected by the request
    logic [3:0] match; // page and space match, any valid
    logic [3:0] vmatch; // match with valid entry
    logic [3:0] wvalid; // valid bits of the selected set
    assign idx = req_i.vaddr[16:12];

    // per-way compare; 4k pages ignore the two low page bits
    genvar w;
    generate
        for (w = 0; w < mfe_pkg::WAYS; w++)
        begin : g_way
            logic [31:0] dw;
            logic big;
            logic vpn_ok;
            assign dw = data_w[w][idx];
            assign big = dw[mfe_pkg::SZ_BIT];
            assign vpn_ok = big ?
                (tag_vpn[w][idx][21:2] == req_i.vaddr[31:12]) :
                (tag_vpn[w][idx] == req_i.vaddr[31:10]);
            assign match[w] = vpn_ok && (dw[mfe_pkg::SH_BIT] ||
                tag_asid[w][idx] == req_i.asid);
            assign wvalid[w] = tag_v[w][idx];
            assign vmatch[w] = match[w] && wvalid[w];
        end
    endgenerate

    // ==================================================
    // fault classification
    logic [1:0] hit_way;
    logic [1:0] inv_way;
    logic [31:0] hit_data;
    logic rights_ok;
    logic zone;
    assign hit_way = first_one(vmatch);
    assign inv_way = first_one(match);
    assign hit_data = data_w[hit_way][idx];
    // rights: bit1 opens to user, bit0 allows writes
    assign rights_ok = (req_i.priv || hit_data[mfe_pkg::PR_LSB+1]) &&
        (!req_i.store || hit_data[mfe_pkg::PR_LSB]);
    // loop zone: just before loop, short loop, or last four instructions
    assign zone = req_i.rpt_pre || (req_i.rpt_active &&
        (req_i.rpt_len < mfe_pkg::RPT_TAIL ||
         req_i.rpt_pos >= req_i.rpt_len - mfe_pkg::RPT_TAIL));

    logic done;
    logic fault;
    mfe_pkg::mfe_fault_t info;
    logic [31:0] paddr;
    logic [31:0] page_entry_high;
    logic [1:0] rc;
    logic next_done;
    logic next_fault;
    mfe_pkg::mfe_fault_t next_info;
    logic [31:0] next_paddr;
    logic [31:0] next_page_entry_high;
    logic [1:0] next_rc;

    // next fault state, page entry high and replacement field
    always_comb
    begin
        logic flt;
        logic [11:0] code;
        logic [31:0] vec;
        flt = 1'b1;
        code = mfe_pkg::EC_IPW;
        vec = mfe_pkg::VEC_GEN;
        next_done = 1'b0;
        next_fault = 1'b0;
        next_info = info;
        next_paddr = paddr;
        next_page_entry_high = page_entry_high_wr_i ? page_entry_high_wdata_i : page_entry_high;
        next_rc = rc_wr_i ? rc_wdata_i : rc;
        if (req_valid_i)
        begin
            // address error outside loop zone belongs to the core
            next_done = !req_i.adr_err || zone;
            if (req_i.adr_err)
            begin
                flt = zone;
                code = mfe_pkg::EC_RPT_MISS;
            end
            else if (match == 4'h0)
            begin
                // miss
                code = zone ? mfe_pkg::EC_RPT_MISS :
                    (req_i.store ? mfe_pkg::EC_MISS_ST :
                     mfe_pkg::EC_MISS_LD);
                vec = zone ? mfe_pkg::VEC_GEN : mfe_pkg::VEC_MISS;
                next_rc = (wvalid == 4'hf) ? rc + 2'h1 :
                    first_one(~wvalid);
            end
            else if (vmatch == 4'h0)
            begin
                // invalid entry matched
                code = zone ? mfe_pkg::EC_RPT_MISS :
                    (req_i.store ? mfe_pkg::EC_INV_ST :
                     mfe_pkg::EC_INV_LD);
                next_rc = inv_way;
            end
            else if (!rights_ok)
            begin
                code = zone ? mfe_pkg::EC_RPT_PROT :
                    (req_i.store ? mfe_pkg::EC_PROT_ST :
                     mfe_pkg::EC_PROT_LD);
                next_rc = hit_way;
            end
            else if (req_i.store && !hit_data[mfe_pkg::D_BIT])
            begin
                code = mfe_pkg::EC_IPW;
                next_rc = hit_way;
            end
            else
            begin
                // clean translation
                flt = 1'b0;
                next_paddr = hit_data[mfe_pkg::SZ_BIT] ?
                    {3'h0, hit_data[mfe_pkg::PPN_MSB:mfe_pkg::PG4K_LSB],
                     req_i.vaddr[11:0]} :
                    {3'h0, hit_data[mfe_pkg::PPN_MSB:mfe_pkg::VPN_LSB],
                     req_i.vaddr[9:0]};
            end
            if (flt)
            begin
                // loop zone faults save the pc like any other fault; the code marks all but an initial write, and a loop zone miss also takes base plus 100, not 400
                next_fault = 1'b1;
                next_info.code = code;
                next_info.vector = vbr_i + vec;
                next_info.fault_address_reg = req_i.vaddr;
                next_page_entry_high = {req_i.vaddr[31:10], page_entry_high[9:0]};
                next_info.saved_program_counter = req_i.dslot ? req_i.br_pc : req_i.pc;
                next_info.saved_status_reg = req_i.sr;
                next_info.sr = req_i.sr;
                next_info.sr[mfe_pkg::SR_MD] = 1'b1;
                next_info.sr[mfe_pkg::SR_BL] = 1'b1;
                next_info.sr[mfe_pkg::SR_RB] = 1'b1;
            end
        end
    end

    // fault state registers
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            done <= 1'b0;
            fault <= 1'b0;
            info <= '0;
            paddr <= 32'h0;
            page_entry_high <= 32'h0;
            rc <= 2'h0;
        end
        else
        begin
            done <= next_done;
            fault <= next_fault;
            info <= next_info;
            paddr <= next_paddr;
            page_entry_high <= next_page_entry_high;
            rc <= next_rc;
        end
    end

    assign done_o = done;
    assign fault_o = fault;
    assign fault_info_o = info;
    assign paddr_o = paddr;
    assign page_entry_high_o = page_entry_high;
    assign replacement_way_field_o = rc;

    // ==================================================
    // entry writes and mapped window
    mfe_pkg::mfe_win_t wk;
    logic [4:0] widx;
    logic [1:0] wway;
    logic win_ok;
    assign wk = win_kind(win_addr_i[31:mfe_pkg::WIN_SEL_LSB]);
    assign widx = win_addr_i[mfe_pkg::WIN_IDX_LSB+4:mfe_pkg::WIN_IDX_LSB];
    assign wway = win_addr_i[mfe_pkg::WIN_WAY_LSB+1:mfe_pkg::WIN_WAY_LSB];
    // privileged longword only; an entry load wins the write port
    assign win_ok = win_valid_i && win_long_i && win_priv_i &&
        wk != mfe_pkg::WIN_NONE && !(win_wr_i && load_translation_entry_instr_i);

    logic ack;
    logic err;
    logic [31:0] rdata;
    logic next_ack;
    logic next_err;
    logic [31:0] next_rdata;

    // window answer
    always_comb
    begin
        next_ack = win_valid_i;
        next_err = win_valid_i && !win_ok;
        next_rdata = 32'h0;
        if (win_ok && !win_wr_i)
        begin
            if (wk == mfe_pkg::WIN_TAGS)
            begin
                next_rdata = {tag_vpn[wway][widx], 2'h0, tag_asid[wway][widx]};
                next_rdata[16:12] = 5'h0;
                next_rdata[mfe_pkg::V_BIT] = tag_v[wway][widx];
            end
            else
            begin
                next_rdata = data_w[wway][widx];
                next_rdata[mfe_pkg::V_BIT] = tag_v[wway][widx];
            end
        end
    end

    // store writes: entry load from page entry registers, or window
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ack <= 1'b0;
            err <= 1'b0;
            rdata <= 32'h0;
            for (int i = 0; i < mfe_pkg::WAYS; i++)
                for (int j = 0; j < mfe_pkg::SETS; j++)
                begin
                    // whole store cleared so compares never see unknowns
                    tag_v[i][j] <= 1'b0;
                    tag_vpn[i][j] <= '0;
                    tag_asid[i][j] <= '0;
                    data_w[i][j] <= 32'h0;
                end
        end
        else
        begin
            ack <= next_ack;
            err <= next_err;
            rdata <= next_rdata;
            if (load_translation_entry_instr_i)
            begin
                tag_vpn[rc][page_entry_high[16:12]] <= page_entry_high[31:10];
                tag_asid[rc][page_entry_high[16:12]] <= page_entry_high[7:0];
                tag_v[rc][page_entry_high[16:12]] <= page_entry_low_i[mfe_pkg::V_BIT];
                data_w[rc][page_entry_high[16:12]] <= page_entry_low_i;
            end
            else if (win_ok && win_wr_i)
            begin
                tag_v[wway][widx] <= win_wdata_i[mfe_pkg::V_BIT];
                if (wk == mfe_pkg::WIN_TAGS)
                begin
                    tag_vpn[wway][widx] <= win_wdata_i[31:10];
                    tag_asid[wway][widx] <= win_wdata_i[7:0];
                end
                else
                    data_w[wway][widx] <= win_wdata_i;
            end
        end
    end

    assign win_ack_o = ack;
    assign win_err_o = err;
    assign win_rdata_o = rdata;

    // ==================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic clean;
    assign clean = req_valid_i && !req_i.adr_err && !zone;

    chk_prot_code: assert property (
        clean && vmatch != 4'h0 && !rights_ok |=> fault_o &&
        fault_info_o.code == ($past(req_i.store) ? 12'h0c0 : 12'h0a0))
        else $error("protection code wrong");
    chk_inv_code: assert property (
        clean && match != 4'h0 && vmatch == 4'h0 |=> fault_o &&
        fault_info_o.code == ($past(req_i.store) ? 12'h060 : 12'h040))
        else $error("invalid entry code wrong");
    chk_ipw_code: assert property (
        clean && vmatch != 4'h0 && rights_ok && req_i.store &&
        !hit_data[mfe_pkg::D_BIT] |=> fault_info_o.code == 12'h080)
        else $error("initial write code wrong");
    chk_fault_capture: assert property (
        fault_o |-> fault_info_o.fault_address_reg[31:10] == page_entry_high_o[31:10])
        else $error("address capture mismatch");
    chk_saved_pc: assert property (
        req_valid_i && req_i.dslot && !req_i.adr_err ##1 fault_o
        |-> fault_info_o.saved_program_counter == $past(req_i.br_pc))
        else $error("saved pc not branch");
    chk_status_bits: assert property (
        fault_o |-> fault_info_o.sr[30:28] == 3'h7 &&
        fault_info_o.saved_status_reg == $past(req_i.sr))
        else $error("status save wrong");
    chk_way_record: assert property (
        clean && match != 4'h0 && vmatch == 4'h0
        |=> replacement_way_field_o == $past(inv_way))
        else $error("faulting way not recorded");
    chk_gen_vector: assert property (
        clean && match != 4'h0 ##1 fault_o
        |-> fault_info_o.vector == $past(vbr_i) + 32'h100)
        else $error("general vector wrong");
    chk_miss_vector: assert property (
        clean && match == 4'h0 |=> fault_o &&
        fault_info_o.vector == $past(vbr_i) + 32'h400)
        else $error("miss vector wrong");
    chk_miss_full: assert property (
        clean && match == 4'h0 && wvalid == 4'hf && !rc_wr_i
        |=> replacement_way_field_o == $past(rc) + 2'h1)
        else $error("round robin step wrong");
    chk_loop_code: assert property (
        req_valid_i && zone && !req_i.adr_err && vmatch != 4'h0 &&
        !rights_ok |=> fault_info_o.code == 12'h0d0)
        else $error("loop protection code wrong");

    cov_prot: cover property (fault_o && fault_info_o.code == 12'h0a0);
    cov_miss: cover property (fault_o && fault_info_o.code == 12'h060);
    cov_clean: cover property (done_o && !fault_o);
    cov_window: cover property (win_ack_o && !win_err_o);
endmodule : mfe_top

// ### rtl/mfe_pkg.sv
/*
 * mfe_pkg: constants and carrier types for the translation fault unit.
 * assumes a 32-bit core, 4-way translation store of 32 sets per way.
 */
package mfe_pkg;
    // ==================================================
    // geometry
    localparam int WAYS = 4;
    localparam int SETS = 32;
    localparam int WAY_W = 2;
    localparam int IDX_W = 5;
    // ==================================================
    // event codes
    localparam logic [11:0] EC_MISS_LD = 12'h040;
    localparam logic [11:0] EC_MISS_ST = 12'h060;
    localparam logic [11:0] EC_INV_LD = 12'h040;
    localparam logic [11:0] EC_INV_ST = 12'h060;
    localparam logic [11:0] EC_PROT_LD = 12'h0a0;
    localparam logic [11:0] EC_PROT_ST = 12'h0c0;
    localparam logic [11:0] EC_IPW = 12'h080;
    localparam logic [11:0] EC_RPT_MISS = 12'h070;
    localparam logic [11:0] EC_RPT_PROT = 12'h0d0;
    // ==================================================
    // vector offsets
    localparam logic [31:0] VEC_GEN = 32'h00000100;
    localparam logic [31:0] VEC_MISS = 32'h00000400;
    // ==================================================
    // processor status bit positions
    localparam int SR_MD = 30;
    localparam int SR_RB = 29;
    localparam int SR_BL = 28;
    // ==================================================
    // mapped window decode
    localparam logic [7:0] WIN_TAG_SEL = 8'hf2;
    localparam logic [7:0] WIN_DATA_SEL = 8'hf3;
    localparam int WIN_SEL_LSB = 24;
    localparam int WIN_IDX_LSB = 12;
    localparam int WIN_WAY_LSB = 8;
    // ==================================================
    // entry word fields (tag word and data word)
    localparam int VPN_LSB = 10;
    localparam int VPN_W = 22;
    localparam int V_BIT = 8;
    localparam int ASID_W = 8;
    localparam int PR_LSB = 5;
    localparam int SZ_BIT = 4;
    localparam int D_BIT = 2;
    localparam int SH_BIT = 1;
    localparam int PPN_MSB = 28;
    localparam int PG4K_LSB = 12;
    // repeat loop tail length where special codes apply
    localparam logic [7:0] RPT_TAIL = 8'h04;

    // window kind
    typedef enum logic [1:0] {
        WIN_NONE = 2'b00,
        WIN_TAGS = 2'b01,
        WIN_DATAS = 2'b10
    } mfe_win_t;

    // one translated access offered by the core
    typedef struct packed {
        logic [31:0] vaddr;
        logic [31:0] pc;
        logic [31:0] br_pc;
        logic [31:0] sr;
        logic [7:0] asid;
        logic store;
        logic priv;
        logic dslot;
        logic adr_err;
        logic rpt_pre;
        logic rpt_active;
        logic [7:0] rpt_len;
        logic [7:0] rpt_pos;
    } mfe_req_t;

    // state captured when a fault is taken
    typedef struct packed {
        logic [11:0] code;
        logic [31:0] vector;
        logic [31:0] saved_program_counter;
        logic [31:0] saved_status_reg;
        logic [31:0] sr;
        logic [31:0] fault_address_reg;
    } mfe_fault_t;
endpackage : mfe_pkg

// ### verification/mfe_core_model.sv
/*
 * mfe_core_model: handler side of the core facing the fault unit.
 * assumes the bench supplies the page table word and starts plain loads.
 */
module mfe_core_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic fault_i,
    input wire logic [11:0] code_i,
    input wire logic go_i,
    input wire logic [3:0] slow_i,
    input wire logic [31:0] ptw_i,
    output logic load_translation_entry_instr_o,
    output logic [31:0] pel_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==================================================
    // handler sequence
    logic [31:0] word; // page table word being installed
    // a load or initial-write handler: wait, then two entry loads
    initial
    begin
        load_translation_entry_instr_o = 1'b0;
        busy_o = 1'b0;
        word = 32'h0;
        forever
        begin
            @(posedge mclk_i);
            if (!rst_i && (go_i || (fault_i && code_i === 12'h080)))
            begin
                busy_o <= 1'b1;
                word = ptw_i;
                // page marked written before it is reloaded
                if (!go_i)
                    word[2] = 1'b1;
                repeat (slow_i) @(posedge mclk_i);
                load_translation_entry_instr_o <= 1'b1;
                @(posedge mclk_i);
                load_translation_entry_instr_o <= 1'b0;
                @(posedge mclk_i);
                load_translation_entry_instr_o <= 1'b1;
                @(posedge mclk_i);
                load_translation_entry_instr_o <= 1'b0;
                busy_o <= 1'b0;
            end
        end
    end
    // idle word is inverted so nothing leans on a stale value
    assign pel_o = busy_o ? word : ~word;
endmodule : mfe_core_model

// ### verification/mfe_top_tb_top.sv
/*
 * mfe_top_tb_top: self-checking bench for the translation fault unit.
 * assumes mfe_top and mfe_core_model; one clock, synchronous reset.
 */
module mfe_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ==================================================
    // signals
    localparam logic [31:0] PC = 32'h8000_0100; // faulting pc
    localparam logic [31:0] BPC = 32'h8000_00fc; // branch before slot
    localparam logic [31:0] SRV = 32'h0000_00f0; // status at fault
    logic mclk_i, rst_i, req_valid_i, load_translation_entry_instr_i, page_entry_high_wr_i, rc_wr_i;
    logic win_valid_i, win_wr_i, win_long_i, win_priv_i, go, busy;
    logic done_o, fault_o, win_ack_o, win_err_o;
    logic [31:0] vbr_i, page_entry_low_i, page_entry_high_wdata_i, win_addr_i;
    logic [31:0] win_wdata_i, paddr_o, page_entry_high_o, win_rdata_o, ptw;
    logic [1:0] rc_wdata_i, replacement_way_field_o;
    logic [3:0] slow;
    mfe_pkg::mfe_req_t req_i;
    mfe_pkg::mfe_fault_t fault_info_o;
    int bad_count;
    int tests_run;
    // ==================================================
    // instances
    mfe_top i_dut (.mclk_i, .rst_i, .req_valid_i, .req_i, .vbr_i, .load_translation_entry_instr_i,
        .page_entry_low_i, .page_entry_high_wr_i, .page_entry_high_wdata_i, .rc_wr_i, .rc_wdata_i,
        .win_valid_i, .win_wr_i, .win_long_i, .win_priv_i, .win_addr_i,
        .win_wdata_i, .done_o, .fault_o, .fault_info_o, .paddr_o,
        .page_entry_high_o, .replacement_way_field_o, .win_ack_o,
        .win_err_o, .win_rdata_o);
    mfe_core_model i_core (.mclk_i, .rst_i, .fault_i(fault_o),
        .code_i(fault_info_o.code), .go_i(go), .slow_i(slow), .ptw_i(ptw),
        .load_translation_entry_instr_o(load_translation_entry_instr_i), .pel_o(page_entry_low_i), .busy_o(busy));
    // free running clock
    always #20 mclk_i = ~mclk_i;
    // ==================================================
    // tasks
    task automatic conclude();
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    // one comparison, reported at once on a miss
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    // wait for the handler model under a bound
    task automatic idle();
        for (int n = 0; n < 40; n++)
        begin
            @(posedge mclk_i);
            // look after the model's update at this edge has landed
            #1;
            if (busy === 1'b0)
                return;
        end
        bad_count++;
        conclude();
    endtask : idle
    // install an entry through page_entry_high, way field and entry load
    task automatic load(input logic [31:0] va, input logic [31:0] w,
                        input logic [1:0] way);
        @(posedge mclk_i);
        page_entry_high_wr_i <= 1'b1;
        page_entry_high_wdata_i <= {va[31:10], 10'h000};
        rc_wr_i <= 1'b1;
        rc_wdata_i <= way;
        ptw <= w;
        go <= 1'b1;
        @(posedge mclk_i);
        page_entry_high_wr_i <= 1'b0;
        rc_wr_i <= 1'b0;
        go <= 1'b0;
        idle();
    endtask : load
    // one lookup; fl is {dslot, adr_err, rpt_pre, rpt_active}
    task automatic look(input logic [31:0] va, input logic st,
                        input logic pv, input logic [3:0] fl,
                        input logic [7:0] len, input logic [7:0] pos);
        @(posedge mclk_i);
        req_i <= '{vaddr: va, pc: PC, br_pc: BPC, sr: SRV, asid: 8'h00,
                   store: st, priv: pv, dslot: fl[3], adr_err: fl[2],
                   rpt_pre: fl[1], rpt_active: fl[0], rpt_len: len,
                   rpt_pos: pos};
        req_valid_i <= 1'b1;
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        #1;
    endtask : look
    // fault outcome; way[2] set skips the way field
    task automatic expf(input logic [11:0] code, input logic [31:0] off,
                        input logic [2:0] way);
        chk({30'h0, done_o, fault_o}, 32'h3);
        chk({20'h0, fault_info_o.code}, {20'h0, code});
        chk(fault_info_o.vector, vbr_i + off);
        if (code != 12'h070 && code != 12'h0d0)
            chk(fault_info_o.saved_program_counter, req_i.dslot ? BPC : PC);
        chk(fault_info_o.saved_status_reg, SRV);
        chk(fault_info_o.sr, SRV | 32'h7000_0000);
        chk(fault_info_o.fault_address_reg, req_i.vaddr);
        chk({page_entry_high_o[31:10], 10'h0}, {req_i.vaddr[31:10], 10'h0});
        if (!way[2])
            chk({30'h0, replacement_way_field_o}, {30'h0, way[1:0]});
    endtask : expf
    // clean translation outcome
    task automatic ok(input logic [31:0] pa);
        chk({30'h0, done_o, fault_o}, 32'h2);
        chk({3'h0, paddr_o[28:0]}, pa);
    endtask : ok
    // window access; k is {write, longword, privileged}
    task automatic win(input logic [2:0] k, input logic [31:0] a,
                       input logic [31:0] wd, input logic er,
                       input logic [31:0] rd);
        @(posedge mclk_i);
        {win_wr_i, win_long_i, win_priv_i} <= k;
        win_addr_i <= a;
        win_wdata_i <= wd;
        win_valid_i <= 1'b1;
        @(posedge mclk_i);
        win_valid_i <= 1'b0;
        #1;
        chk({30'h0, win_ack_o, win_err_o}, {30'h0, 1'b1, er});
        chk(win_rdata_o, rd);
    endtask : win
    // ==================================================
    // main sequence
    initial
    begin
        {mclk_i, req_valid_i, page_entry_high_wr_i, rc_wr_i, go} = '0;
        {win_valid_i, win_wr_i, win_long_i, win_priv_i} = '0;
        {page_entry_high_wdata_i, win_addr_i, win_wdata_i, ptw} = '0;
        rc_wdata_i = 2'h0;
        req_i = '0;
        slow = 4'h0;
        vbr_i = 32'h8c00_0000;
        bad_count = 0;
        tests_run = 0;
        rst_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1;
        chk(page_entry_high_o, 32'h0);
        win(3'b011, 32'hf300_1000, 32'h0, 1'b0, 32'h0);
        load(32'h0000_1000, 32'h0a00_0130, 2'd0);
        load(32'h0000_2000, 32'h0b00_0030, 2'd1);
        load(32'h0000_3000, 32'h0c00_0174, 2'd2);
        win(3'b011, 32'hf300_1000, 32'h0, 1'b0, 32'h0a00_0130);
        win(3'b011, 32'hf200_1000, 32'h0, 1'b0, 32'h0000_0100);
        win(3'b001, 32'hf300_1000, 32'h0, 1'b1, 32'h0);
        win(3'b010, 32'hf300_1000, 32'h0, 1'b1, 32'h0);
        win(3'b011, 32'hf400_1000, 32'h0, 1'b1, 32'h0);
        look(32'h0000_1234, 1'b0, 1'b1, 4'h0, 8'd0, 8'd0);
        ok(32'h0a00_0234);
        look(32'h0000_1234, 1'b0, 1'b0, 4'h0, 8'd0, 8'd0);
        expf(mfe_pkg::EC_PROT_LD, mfe_pkg::VEC_GEN, 3'd0);
        look(32'h0000_1234, 1'b1, 1'b0, 4'h0, 8'd0, 8'd0);
        expf(mfe_pkg::EC_PROT_ST, mfe_pkg::VEC_GEN, 3'd0);
        look(32'h0000_2010, 1'b0, 1'b1, 4'h0, 8'd0, 8'd0);
        expf(mfe_pkg::EC_INV_LD, mfe_pkg::VEC_GEN, 3'd1);
        look(32'h0000_2010, 1'b1, 1'b1, 4'h8, 8'd0, 8'd0);
        expf(mfe_pkg::EC_INV_ST, mfe_pkg::VEC_GEN, 3'd1);
        look(32'h0000_3008, 1'b1, 1'b0, 4'h0, 8'd0, 8'd0);
        ok(32'h0c00_0008);
        look(32'h0002_1000, 1'b0, 1'b1, 4'h0, 8'd0, 8'd0);
        expf(mfe_pkg::EC_MISS_LD, mfe_pkg::VEC_MISS, 3'd1);
        look(32'h0000_5000, 1'b1, 1'b1, 4'h0, 8'd0, 8'd0);
        expf(mfe_pkg::EC_MISS_ST, mfe_pkg::VEC_MISS, 3'd0);
        look(32'h0000_5000, 1'b0, 1'b1, 4'h1, 8'd6, 8'd1);
        expf(mfe_pkg::EC_MISS_LD, mfe_pkg::VEC_MISS, 3'd0);
        look(32'h0000_5000, 1'b0, 1'b1, 4'h1, 8'd6, 8'd2);
        expf(mfe_pkg::EC_RPT_MISS, mfe_pkg::VEC_GEN, 3'd0);
        look(32'h0000_1234, 1'b0, 1'b0, 4'h2, 8'd0, 8'd0);
        expf(mfe_pkg::EC_RPT_PROT, mfe_pkg::VEC_GEN, 3'd0);
        look(32'h0000_2010, 1'b0, 1'b1, 4'h1, 8'd3, 8'd0);
        expf(mfe_pkg::EC_RPT_MISS, mfe_pkg::VEC_GEN, 3'd1);
        look(32'h0000_1234, 1'b0, 1'b1, 4'h5, 8'd8, 8'd7);
        expf(mfe_pkg::EC_RPT_MISS, mfe_pkg::VEC_GEN, 3'd4);
        look(32'h0000_1234, 1'b0, 1'b1, 4'h4, 8'd0, 8'd0);
        chk({30'h0, done_o, fault_o}, 32'h0);
        // initial write: slow handler marks the page and reloads it
        slow <= 4'h5;
        ptw <= 32'h0a00_0130;
        look(32'h0000_1234, 1'b1, 1'b1, 4'h0, 8'd0, 8'd0);
        expf(mfe_pkg::EC_IPW, mfe_pkg::VEC_GEN, 3'd0);
        idle();
        look(32'h0000_1234, 1'b1, 1'b1, 4'h0, 8'd0, 8'd0);
        ok(32'h0a00_0234);
        // valid bit set through the data window, seen by lookup and tags
        win(3'b111, 32'hf300_2100, 32'h0b00_0130, 1'b0, 32'h0);
        look(32'h0000_2010, 1'b0, 1'b1, 4'h0, 8'd0, 8'd0);
        ok(32'h0b00_0010);
        win(3'b011, 32'hf200_2100, 32'h0, 1'b0, 32'h0000_0100);
        conclude();
    end
endmodule : mfe_top_tb_top
